/* File: core/expander_mode_regs.sv */
// Configuration and transition-mask registers of the port expander.
// Assumes the serial frame logic delivers one-cycle write strobes.
module expander_mode_regs
   import expander_mode_pkg::*;
(
   input wire logic i_clk,
   input wire logic i_resetn,
   input wire logic i_wr,
   input wire logic [6:0] i_addr,
   input wire logic [7:0] i_wdata,
   input wire logic [MASK_WIDTH-1:0] i_port,
   output logic [7:0] o_rdata,
   output logic o_shutdown,
   output logic o_detect_en,
   output logic [MASK_WIDTH-1:0] o_mask,
   output logic o_change
);
   // ----------------------------------------
   // Write decode
   // ----------------------------------------
   logic cfg_sel;
   logic mask_sel;
   logic cfg_wr;
   logic mask_wr;

   assign cfg_sel = (i_addr == MODE_CONFIG_ADDR);
   assign mask_sel = (i_addr == CHANGE_MASK_ADDR);
   assign cfg_wr = i_wr && cfg_sel;
   assign mask_wr = i_wr && mask_sel;

   // ----------------------------------------
   // Configuration register
   // ----------------------------------------
   logic run_r, run_nxt;
   logic detect_r, detect_nxt;

   always_comb begin
      run_nxt = run_r;
      detect_nxt = detect_r;
      if (cfg_wr) begin
         run_nxt = i_wdata[RUN_BIT];
         detect_nxt = i_wdata[DETECT_BIT];
      end
   end

   always_ff @(posedge i_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         run_r <= MODE_CONFIG_RESET[RUN_BIT];
         detect_r <= MODE_CONFIG_RESET[DETECT_BIT];
      end else begin
         run_r <= run_nxt;
         detect_r <= detect_nxt;
      end
   end

   // ----------------------------------------
   // Transition mask register
   // ----------------------------------------
   logic [MASK_WIDTH-1:0] mask_r, mask_nxt;

   always_comb begin
      mask_nxt = mask_r;
      if (mask_wr) begin
         mask_nxt = i_wdata[MASK_WIDTH-1:0];
      end
   end

   always_ff @(posedge i_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         mask_r <= CHANGE_MASK_RESET;
      end else begin
         mask_r <= mask_nxt;
      end
   end

   // ----------------------------------------
   // Read data
   // ----------------------------------------
   logic [7:0] rdata_r, rdata_nxt;

   always_comb begin
      rdata_nxt = READ_ZERO;
      if (cfg_sel) begin
         rdata_nxt[RUN_BIT] = run_r;
         rdata_nxt[DETECT_BIT] = detect_r;
      end else if (mask_sel) begin
         rdata_nxt[MASK_WIDTH-1:0] = mask_r;
      end
   end

   always_ff @(posedge i_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         rdata_r <= READ_ZERO;
      end else begin
         rdata_r <= rdata_nxt;
      end
   end

   // ----------------------------------------
   // Outputs
   // ----------------------------------------
   assign o_shutdown = !run_r;
   assign o_detect_en = detect_r;
   assign o_mask = mask_r;
   assign o_rdata = rdata_r;

   // ----------------------------------------
   // Change detection
   // ----------------------------------------
   change_detect #(.WIDTH(MASK_WIDTH)) u_detect (
      .i_clk(i_clk),
      .i_resetn(i_resetn),
      .i_enable(detect_r),
      .i_mask(mask_r),
      .i_port(i_port),
      .o_change(o_change)
   );

   // ----------------------------------------
   // Assertion defaults
   // ----------------------------------------
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_resetn);

   // ----------------------------------------
   // Configuration checks
   // ----------------------------------------
   a_shutdown_entry: assert property ((cfg_wr && !i_wdata[RUN_BIT])
      |=> o_shutdown)
      else $error("shutdown not entered");

   a_normal_entry: assert property ((cfg_wr && i_wdata[RUN_BIT])
      |=> !o_shutdown)
      else $error("normal mode not entered");

   a_detect_ctrl: assert property (cfg_wr
      |=> o_detect_en == $past(i_wdata[DETECT_BIT]))
      else $error("detect enable wrong");

   a_detect_indep: assert property ((cfg_wr
      && !i_wdata[RUN_BIT] && i_wdata[DETECT_BIT])
      |=> o_shutdown && o_detect_en)
      else $error("detect enable tied to shutdown");

   a_cfg_hold: assert property (!cfg_wr
      |=> $stable(o_shutdown) && $stable(o_detect_en))
      else $error("config changed without write");

   a_reset_cfg: assert property ($rose(i_resetn)
      |-> o_shutdown && !o_detect_en)
      else $error("config not at reset value");

   // ----------------------------------------
   // Mask checks
   // ----------------------------------------
   a_mask_write: assert property (mask_wr
      |=> o_mask == $past(i_wdata[MASK_WIDTH-1:0]))
      else $error("mask not written");

   a_mask_hold: assert property (!mask_wr |=> $stable(o_mask))
      else $error("mask changed without write");

   a_mask_reset: assert property ($rose(i_resetn)
      |-> o_mask == CHANGE_MASK_RESET)
      else $error("mask not clear after reset");

   a_other_write: assert property ((i_wr && !cfg_sel && !mask_sel)
      |=> $stable(o_mask) && $stable(o_shutdown) && $stable(o_detect_en))
      else $error("write to unused address took effect");

   // ----------------------------------------
   // Read-back checks
   // ----------------------------------------
   a_mask_read: assert property (mask_sel
      |=> o_rdata == {1'b0, $past(mask_r)})
      else $error("mask readback wrong");

   a_mask_top: assert property (mask_sel |=> !o_rdata[MASK_WIDTH])
      else $error("mask top bit not zero");

   a_cfg_read: assert property (cfg_sel
      |=> o_rdata[RUN_BIT] == $past(run_r)
      && o_rdata[DETECT_BIT] == $past(detect_r))
      else $error("config readback wrong");

   a_unused_zero: assert property ((!cfg_sel && !mask_sel)
      |=> o_rdata == READ_ZERO)
      else $error("unused bits not zero");

   a_cfg_gaps: assert property (o_rdata[DETECT_BIT-1:RUN_BIT+1] == '0
      || $past(mask_sel))
      else $error("config gap bits set");

   a_rdata_reset: assert property ($rose(i_resetn)
      |-> o_rdata == READ_ZERO)
      else $error("read data not clear after reset");

   // ----------------------------------------
   // Change checks
   // ----------------------------------------
   a_change_cause: assert property (o_change |-> $past(detect_r)
      && |($past(mask_r) & ($past(i_port) ^ $past(i_port, 2))))
      else $error("spurious change event");

   a_change_fire: assert property ((o_detect_en
      && |(o_mask & (i_port ^ $past(i_port)))) |=> o_change)
      else $error("change event missed");

   a_change_quiet: assert property (!o_detect_en |=> !o_change)
      else $error("change event while detection off");

   a_change_masked: assert property ((o_mask == '0) |=> !o_change)
      else $error("change event with all ports masked");

   for (genvar g = 0; g < MASK_WIDTH; g++) begin : g_port_chk
      a_port_change: assert property ((o_detect_en && o_mask[g]
         && i_port[g] != $past(i_port[g])) |=> o_change)
         else $error("unmasked port change missed");
   end

   // ----------------------------------------
   // Coverage
   // ----------------------------------------
   c_shutdown: cover property (o_shutdown ##1 !o_shutdown);
   c_detect_off: cover property (o_detect_en ##1 !o_detect_en);
   c_mask_set: cover property (o_mask == {MASK_WIDTH{1'b1}});
   c_mask_readback: cover property (mask_sel ##1 o_rdata != READ_ZERO);
   c_change: cover property (o_change);
endmodule : expander_mode_regs

/* File: core/expander_mode_pkg.sv */
// Constants for the mode and change-mask register block.
// Assumes a register write/read port already decoded from the serial frame.
// Operation
// - Writing configuration bit 0 as zero puts the device into shutdown.
// - Writing configuration bit 0 as one selects normal operation.
// - Configuration bit 7 enables transition detection, independent of shutdown.
// - Mask register at 0x06 holds bits 0 to 6 for ports 24 to 30.
// - Mask bit 7 reads zero and writes to it are ignored.
// - At power-up all mask bits are clear, every port masked off.
// - Register bits without function read back as zero.
package expander_mode_pkg;
   localparam logic [6:0] MODE_CONFIG_ADDR = 7'h04;
   localparam logic [6:0] CHANGE_MASK_ADDR = 7'h06;
   localparam int RUN_BIT = 0;
   localparam int DETECT_BIT = 7;
   localparam int MASK_WIDTH = 7;
   localparam logic [7:0] MODE_CONFIG_RESET = 8'h00;
   localparam logic [6:0] CHANGE_MASK_RESET = 7'h00;
   localparam logic [7:0] READ_ZERO = 8'h00;
endpackage : expander_mode_pkg

/* File: core/change_detect.sv */
// Transition detector for the maskable upper ports.
// Assumes port levels are synchronous to i_clk.
module change_detect
   import expander_mode_pkg::*;
#(
   parameter int WIDTH = MASK_WIDTH
) (
   input wire logic i_clk,
   input wire logic i_resetn,
   input wire logic i_enable,
   input wire logic [WIDTH-1:0] i_mask,
   input wire logic [WIDTH-1:0] i_port,
   output logic o_change
);
   logic [WIDTH-1:0] last_r, last_nxt;
   logic change_r, change_nxt;

   always_comb begin
      last_nxt = i_port;
      change_nxt = i_enable && |((i_port ^ last_r) & i_mask);
   end

   always_ff @(posedge i_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         last_r <= '0;
         change_r <= 1'b0;
      end else begin
         last_r <= last_nxt;
         change_r <= change_nxt;
      end
   end

   assign o_change = change_r;
endmodule : change_detect

/* File: dv/expander_host.sv */
// Host model: drives register writes and reads.
// Assumes the block takes its inputs on the rising clock edge.
module expander_host
   import expander_mode_pkg::*;
(
   input wire logic i_clk,
   output logic o_wr = 1'b0,
   output logic o_rd = 1'b0,
   output logic [6:0] o_addr = 7'h00,
   output logic [7:0] o_wdata = 8'h00
);
   timeunit 1ns;
   timeprecision 1ns;
   // ----
   // Bus cycles
   // ----
   task automatic wr(input logic [6:0] a, input logic [7:0] d);
      @(negedge i_clk);
      o_wr = 1'b1;
      o_addr = a;
      o_wdata = (a == MODE_CONFIG_ADDR) ? (d & 8'hBF) : d;
      @(negedge i_clk);
      o_wr = 1'b0;
   endtask : wr
   task automatic rd(input logic [6:0] a);
      @(negedge i_clk);
      o_rd = 1'b1;
      o_addr = a;
      @(negedge i_clk);
      o_rd = 1'b0;
   endtask : rd
endmodule : expander_host

/* File: dv/expander_mode_and_change_mask_tb_top.sv */
// Testbench: host model drives the registers, reads checked via a queue.
// Assumes one 10 MHz clock.
module expander_mode_and_change_mask_tb_top
   import expander_mode_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
`define CHK(n, e, s) begin n_tests++; if ((s) !== (e)) begin num_errors++; \
   $display("Error %s exp %h got %h", n, e, s); end end
   logic i_clk = 1'b0;
   logic i_resetn = 1'b0;
   logic [6:0] i_port = 7'h00;
   logic wr, rd, shut, det, chg;
   logic rd_d = 1'b0;
   logic [6:0] addr, mask;
   logic [7:0] wdata, rdata, d;
   logic [7:0] exp_r;
   logic [7:0] exp_q[$];
   int num_errors = 0;
   int n_tests = 0;
   always #50 i_clk = ~i_clk;
   expander_host i_host(.i_clk(i_clk), .o_wr(wr), .o_rd(rd),
      .o_addr(addr), .o_wdata(wdata));
   expander_mode_regs i_dut(.i_clk(i_clk), .i_resetn(i_resetn), .i_wr(wr),
      .i_addr(addr), .i_wdata(wdata), .i_port(i_port), .o_rdata(rdata),
      .o_shutdown(shut), .o_detect_en(det), .o_mask(mask), .o_change(chg));
   // ----
   // Checking
   // ----
   always @(posedge i_clk) rd_d <= rd;
   always @(negedge i_clk) begin
      if (rd_d) begin
         exp_r = exp_q.pop_front();
         `CHK("rdata", exp_r, rdata)
      end
   end
   task automatic rd_chk(input logic [6:0] a, input logic [7:0] e);
      exp_q.push_back(e);
      i_host.rd(a);
   endtask : rd_chk
   task automatic tog(input int b, input logic e);
      @(negedge i_clk);
      i_port[b] = ~i_port[b];
      @(negedge i_clk);
      `CHK("change", e, chg)
      @(negedge i_clk);
      `CHK("change", 1'b0, chg)
   endtask : tog
   task automatic report_and_stop();
      $display("Checks %0d errors %0d", n_tests, num_errors);
      if (num_errors == 0 && n_tests > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask : report_and_stop
   initial begin
      #100000;
      num_errors++;
      report_and_stop();
   end
   initial begin
      d = 8'($urandom(67842));
      repeat (12) @(posedge i_clk);
      @(negedge i_clk);
      i_resetn = 1'b1;
      `CHK("shut", 1'b1, shut)
      rd_chk(MODE_CONFIG_ADDR, 8'h00);
      rd_chk(CHANGE_MASK_ADDR, 8'h00);
      i_host.wr(MODE_CONFIG_ADDR, 8'hFF);
      `CHK("shut", 1'b0, shut)
      `CHK("det", 1'b1, det)
      rd_chk(MODE_CONFIG_ADDR, 8'h81);
      i_host.wr(MODE_CONFIG_ADDR, 8'h80);
      `CHK("shut", 1'b1, shut)
      `CHK("det", 1'b1, det)
      repeat (4) begin
         d = 8'($urandom);
         i_host.wr(CHANGE_MASK_ADDR, d);
         `CHK("mask", d[6:0], mask)
         rd_chk(CHANGE_MASK_ADDR, {1'b0, d[6:0]});
      end
      i_host.wr(7'h05, 8'hFF);
      rd_chk(7'h05, 8'h00);
      rd_chk(MODE_CONFIG_ADDR, 8'h80);
      i_host.wr(CHANGE_MASK_ADDR, 8'hFF);
      `CHK("mask", 7'h7F, mask)
      rd_chk(CHANGE_MASK_ADDR, 8'h7F);
      i_host.wr(CHANGE_MASK_ADDR, 8'h81);
      tog(0, 1'b1);
      tog(1, 1'b0);
      i_host.wr(MODE_CONFIG_ADDR, 8'h01);
      tog(0, 1'b0);
      @(negedge i_clk);
      i_resetn = 1'b0;
      repeat (2) @(negedge i_clk);
      i_resetn = 1'b1;
      `CHK("shut", 1'b1, shut)
      `CHK("det", 1'b0, det)
      `CHK("mask", 7'h00, mask)
      rd_chk(CHANGE_MASK_ADDR, 8'h00);
      rd_chk(MODE_CONFIG_ADDR, 8'h00);
      report_and_stop();
   end
endmodule : expander_mode_and_change_mask_tb_top
